// >>> rtl/sssm_map.svh
// register offsets, bit positions, mode codes and divider counts
`ifndef SSSM_MAP_SVH
`define SSSM_MAP_SVH
`define SSSM_ADDR_STATUS   2'h0
`define SSSM_ADDR_CONTROL  2'h1
`define SSSM_ADDR_BUFFER   2'h2
`define SSSM_ADDR_INTFLAG  2'h3
`define SSSM_STAT_SMP      7
`define SSSM_STAT_CKE      6
`define SSSM_STAT_BF       0
`define SSSM_CTL_WRITE_COLLISION_FLAG      7
`define SSSM_CTL_OVF       6
`define SSSM_CTL_EN        5
`define SSSM_CTL_CKP       4
`define SSSM_RESET_STATUS  8'h00
`define SSSM_RESET_CONTROL 8'h00
`define SSSM_MODE_DIV4     4'h0
`define SSSM_MODE_DIV16    4'h1
`define SSSM_MODE_DIV64    4'h2
`define SSSM_MODE_TMR      4'h3
`define SSSM_MODE_SLV_SS   4'h4
`define SSSM_MODE_SLV_FREE 4'h5
`define SSSM_MODE_DIV8     4'hA
`define SSSM_HALF_DIV4     5'h02
`define SSSM_HALF_DIV8     5'h04
`define SSSM_HALF_DIV16    5'h08
`define SSSM_HALF_DIV64    5'h20
`define SSSM_EDGES_BYTE    5'h10
`endif

// >>> rtl/sssm_pkg.sv
// types shared by the serial port block
package sssm_pkg;
  typedef enum logic [0:0] {
    SSSM_IDLE = 1'b0,
    SSSM_RUN  = 1'b1
  } sssm_state_type;
endpackage

// >>> rtl/sssm_port.sv
// spi mode of the synchronous serial port with register port
//
// How it works
// - eight bits out and in together per byte
// - full byte copied to buffer, interrupt set
// - buffer write loads buffer and shifter
// - most significant bit shifts first
// - sample phase picks end or middle sampling in master mode
// - clock edge bit picks output transition
// - polarity bit sets clock idle level
// - buffer full set when a byte completes, cleared on read
// - write while busy ignored, collision flagged
// - slave overrun flags overflow, drops byte
// - master never raises overflow
// - enable bit hands pins to port
// - master codes pick clock divider source
// - slave codes with or without select
// - other mode codes do nothing
// - master drives clock, slave receives it
// - shifter reachable only through buffer
// - status low bits read-only, all reset zero
// - stop bit cleared while disabled
// - high select floats output, clears counter
// - standard modes map to polarity and edge
`timescale 1ns/10ps
`include "sssm_map.svh"
module sssm_port (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       clk_en,
  input  wire logic [1:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic       timer_tick,
  input  wire logic       sck_in,
  output logic            sck_out,
  output logic            sck_oe,
  input  wire logic       sdi_in,
  output logic            sdo_out,
  output logic            sdo_oe,
  input  wire logic       ss_n_in,
  output logic            pins_owned,
  output logic            port_interrupt_flag
);

  ////////////////////////////////////////////////////////////////////////
  // registers and state

  sssm_pkg::sssm_state_type state_r;
  logic [7:0] ctl_r;
  logic       smp_r;
  logic       cke_r;
  logic       bf_r;
  logic       pif_r;
  logic [7:0] buf_r;
  logic [7:0] tx_r;
  logic [7:0] rx_r;
  logic [7:0] rdata_r;
  logic [4:0] div_r;
  logic [4:0] edge_r;
  logic       sck_act_r;
  logic       sck_q_r;
  logic [2:0] bit_cnt_r;

  ////////////////////////////////////////////////////////////////////////
  // mode decode

  wire [3:0] mode    = ctl_r[3:0];
  wire       en      = ctl_r[`SSSM_CTL_EN];
  wire       cpol    = ctl_r[`SSSM_CTL_CKP];
  wire       m_div4  = mode == `SSSM_MODE_DIV4;
  wire       m_div16 = mode == `SSSM_MODE_DIV16;
  wire       m_div64 = mode == `SSSM_MODE_DIV64;
  wire       m_div8  = mode == `SSSM_MODE_DIV8;
  wire       m_tmr   = mode == `SSSM_MODE_TMR;
  wire       s_ss    = mode == `SSSM_MODE_SLV_SS;
  wire       s_free  = mode == `SSSM_MODE_SLV_FREE;
  // any other code leaves both roles off
  wire       is_master = en && (m_div4 || m_div16 || m_div64
                                || m_div8 || m_tmr);
  wire       is_slave  = en && (s_ss || s_free);
  wire       ss_off    = is_slave && s_ss && ss_n_in;
  wire       s_go      = is_slave && !ss_off;

  ////////////////////////////////////////////////////////////////////////
  // master bit clock

  wire [4:0] half_lim = m_div4  ? `SSSM_HALF_DIV4  - 5'h01 :
                        m_div8  ? `SSSM_HALF_DIV8  - 5'h01 :
                        m_div16 ? `SSSM_HALF_DIV16 - 5'h01 :
                                  `SSSM_HALF_DIV64 - 5'h01;
  // timer mode toggles once per tick, giving the tick rate over two
  wire       tick   = m_tmr ? timer_tick : (div_r == half_lim);
  wire       run    = state_r == sssm_pkg::SSSM_RUN;
  wire       m_edge = run && tick;
  wire [4:0] k      = edge_r + 5'h01;
  wire       last_k = k == `SSSM_EDGES_BYTE;
  // odd edges go idle to active; output edge parity follows the edge bit
  wire       out_par = k[0] == !cke_r;
  wire       m_shift = m_edge && out_par && !last_k
                       && (cke_r || k != 5'h01);
  wire       m_samp  = m_edge && (smp_r
                       ? ((out_par && k != 5'h01) || (last_k && !cke_r))
                       : !out_par);
  wire       m_done  = m_edge && last_k;

  ////////////////////////////////////////////////////////////////////////
  // slave clock edges

  // pins are synchronous, so the previous sample is enough for edges
  wire sck_chg = sck_in != sck_q_r;
  wire lead    = sck_chg && sck_in != cpol;
  wire trail   = sck_chg && sck_in == cpol;
  wire s_shift = s_go && (cke_r ? trail : lead)
                 && bit_cnt_r != 3'h0;
  // slave always samples on the other edge; sample phase must be clear
  wire s_samp  = s_go && (cke_r ? lead : trail);
  wire s_done  = s_samp && bit_cnt_r == 3'h7;

  ////////////////////////////////////////////////////////////////////////
  // transfer and register events

  wire       shift_any  = m_shift || s_shift;
  wire       samp_any   = m_samp || s_samp;
  wire       done_any   = m_done || s_done;
  wire [7:0] rx_shifted = {rx_r[6:0], sdi_in};
  // the last master sample can fall on the same edge that ends the byte
  wire [7:0] rx_byte    = samp_any ? rx_shifted : rx_r;
  wire       busy       = run || (s_go && bit_cnt_r != 3'h0);
  wire       wr_buf     = reg_wr && reg_addr == `SSSM_ADDR_BUFFER;
  wire       wr_ctl     = reg_wr && reg_addr == `SSSM_ADDR_CONTROL;
  wire       wr_stat    = reg_wr && reg_addr == `SSSM_ADDR_STATUS;
  wire       wr_intf    = reg_wr && reg_addr == `SSSM_ADDR_INTFLAG;
  wire       rd_buf     = reg_rd && reg_addr == `SSSM_ADDR_BUFFER;
  wire       collide    = wr_buf && busy;
  wire       load       = wr_buf && !busy;
  wire       overrun    = s_done && bf_r;
  wire       accept     = done_any && !overrun;
  wire       start      = load && is_master;

  // control byte: flags set by hardware win over a software clear
  wire       write_collision_flag_nxt = collide
                        || (wr_ctl ? reg_wdata[`SSSM_CTL_WRITE_COLLISION_FLAG]
                                   : ctl_r[`SSSM_CTL_WRITE_COLLISION_FLAG]);
  wire       ovf_nxt  = overrun
                        || (wr_ctl ? reg_wdata[`SSSM_CTL_OVF]
                                   : ctl_r[`SSSM_CTL_OVF]);
  wire [5:0] cfg_nxt  = wr_ctl ? reg_wdata[5:0] : ctl_r[5:0];
  wire [7:0] ctl_nxt  = {write_collision_flag_nxt, ovf_nxt, cfg_nxt};

  // stop bit and other link-only bits stay zero, so disabling clears them
  wire [7:0] status_rd = {smp_r, cke_r, 5'h00, bf_r};
  wire [7:0] rd_mux =
    reg_addr == `SSSM_ADDR_STATUS  ? status_rd :
    reg_addr == `SSSM_ADDR_CONTROL ? ctl_r :
    reg_addr == `SSSM_ADDR_BUFFER  ? buf_r :
                                     {7'h00, pif_r};

  ////////////////////////////////////////////////////////////////////////
  // register file

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctl_r   <= `SSSM_RESET_CONTROL;
      smp_r   <= 1'b0;
      cke_r   <= 1'b0;
      bf_r    <= 1'b0;
      pif_r   <= 1'b0;
      buf_r   <= 8'h00;
      rdata_r <= 8'h00;
    end
    else if (clk_en)
    begin
      ctl_r <= ctl_nxt;
      if (wr_stat)
      begin
        smp_r <= reg_wdata[`SSSM_STAT_SMP];
        cke_r <= reg_wdata[`SSSM_STAT_CKE];
      end
      bf_r  <= accept || (bf_r && !rd_buf);
      pif_r <= accept || (pif_r && !(wr_intf && !reg_wdata[0]));
      if (load)
        buf_r <= reg_wdata;
      else if (accept)
        buf_r <= rx_byte;
      if (reg_rd)
        rdata_r <= rd_mux;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // shifter and sequencing

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r   <= sssm_pkg::SSSM_IDLE;
      tx_r      <= 8'h00;
      rx_r      <= 8'h00;
      div_r     <= 5'h00;
      edge_r    <= 5'h00;
      sck_act_r <= 1'b0;
      sck_q_r   <= 1'b0;
      bit_cnt_r <= 3'h0;
    end
    else if (clk_en)
    begin
      sck_q_r <= sck_in;
      if (load)
        tx_r <= reg_wdata;
      else if (shift_any)
        tx_r <= {tx_r[6:0], 1'b0};
      if (samp_any)
        rx_r <= rx_shifted;
      div_r <= (!run || tick) ? 5'h00 : div_r + 5'h01;
      unique case (state_r)
        sssm_pkg::SSSM_IDLE:
        begin
          edge_r    <= 5'h00;
          sck_act_r <= 1'b0;
          if (start)
            state_r <= sssm_pkg::SSSM_RUN;
        end
        sssm_pkg::SSSM_RUN:
        begin
          if (!is_master || m_done)
            state_r <= sssm_pkg::SSSM_IDLE;
          if (!is_master)
            sck_act_r <= 1'b0;
          else if (m_edge)
          begin
            edge_r    <= k;
            sck_act_r <= !sck_act_r;
          end
        end
      endcase
      if (!s_go)
        bit_cnt_r <= 3'h0;
      else if (s_samp)
        bit_cnt_r <= bit_cnt_r + 3'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pins

  assign sck_out    = cpol ^ sck_act_r;
  assign sck_oe     = is_master;
  assign sdo_out    = tx_r[7];
  assign sdo_oe     = is_master || s_go;
  assign pins_owned = en;
  assign reg_rdata  = rdata_r;
  assign port_interrupt_flag = pif_r;

  ////////////////////////////////////////////////////////////////////////
  // checks

  sequence s_byte_taken;
    bf_r && pif_r;
  endsequence

  sequence s_select_drop;
    !sdo_oe ##1 bit_cnt_r == 3'h0;
  endsequence

  property p_msb_first;
    @(posedge clk) disable iff (!rst_n)
    clk_en && samp_any
      |=> rx_r[0] == $past(sdi_in) && rx_r[7:1] == $past(rx_r[6:0]);
  endproperty
  a_msb_first: assert property (p_msb_first)
    else $error("receive bit not shifted in at lsb");

  property p_byte_to_buffer;
    @(posedge clk) disable iff (!rst_n)
    clk_en && accept && !load |=> s_byte_taken and buf_r == $past(rx_byte);
  endproperty
  a_byte_to_buffer: assert property (p_byte_to_buffer)
    else $error("completed byte not moved to buffer");

  property p_write_both;
    @(posedge clk) disable iff (!rst_n)
    clk_en && load |=> tx_r == $past(reg_wdata) && buf_r == $past(reg_wdata);
  endproperty
  a_write_both: assert property (p_write_both)
    else $error("buffer write did not load shifter and buffer");

  property p_collision;
    @(posedge clk) disable iff (!rst_n)
    clk_en && collide && !accept
      |=> ctl_r[`SSSM_CTL_WRITE_COLLISION_FLAG] && buf_r == $past(buf_r);
  endproperty
  a_collision: assert property (p_collision)
    else $error("busy write not ignored or not flagged");

  property p_overflow;
    @(posedge clk) disable iff (!rst_n)
    clk_en && overrun |=> ctl_r[`SSSM_CTL_OVF] && buf_r == $past(buf_r);
  endproperty
  a_overflow: assert property (p_overflow)
    else $error("slave overrun not flagged or byte kept");

  property p_no_master_ovf;
    @(posedge clk) disable iff (!rst_n)
    clk_en && is_master && !ctl_r[`SSSM_CTL_OVF] && !wr_ctl
      |=> !ctl_r[`SSSM_CTL_OVF];
  endproperty
  a_no_master_ovf: assert property (p_no_master_ovf)
    else $error("overflow raised in master mode");

  property p_bf_clear;
    @(posedge clk) disable iff (!rst_n)
    clk_en && rd_buf && !accept |=> !bf_r;
  endproperty
  a_bf_clear: assert property (p_bf_clear)
    else $error("buffer read did not clear full flag");

  property p_sck_idle;
    @(posedge clk) disable iff (!rst_n)
    !run |-> sck_out == cpol;
  endproperty
  a_sck_idle: assert property (p_sck_idle)
    else $error("clock not at idle level");

  property p_select_high;
    @(posedge clk) disable iff (!rst_n)
    clk_en && ss_off && !wr_ctl |-> s_select_drop;
  endproperty
  a_select_high: assert property (p_select_high)
    else $error("high select did not float output and clear count");

  property p_pins_released;
    @(posedge clk) disable iff (!rst_n)
    !en |-> !sck_oe && !sdo_oe && !pins_owned;
  endproperty
  a_pins_released: assert property (p_pins_released)
    else $error("pins driven while port disabled");

  property p_reserved_idle;
    @(posedge clk) disable iff (!rst_n)
    clk_en && !is_master && !wr_ctl
      |=> state_r == sssm_pkg::SSSM_IDLE && !sck_oe;
  endproperty
  a_reserved_idle: assert property (p_reserved_idle)
    else $error("master activity without a master code");

  property p_master_sixteen;
    @(posedge clk) disable iff (!rst_n)
    clk_en && m_done
      |=> state_r == sssm_pkg::SSSM_IDLE && $past(edge_r) == 5'h0F;
  endproperty
  a_master_sixteen: assert property (p_master_sixteen)
    else $error("master byte did not take sixteen clock edges");

  property p_abort_idle;
    @(posedge clk) disable iff (!rst_n)
    clk_en && run && !is_master |=> !run && sck_out == cpol;
  endproperty
  a_abort_idle: assert property (p_abort_idle)
    else $error("clock not idle after master abort");

  property p_slave_free;
    @(posedge clk) disable iff (!rst_n)
    is_slave && s_free |-> s_go && sdo_oe && !sck_oe;
  endproperty
  a_slave_free: assert property (p_slave_free)
    else $error("free slave mode not ignoring select");

endmodule

// >>> testbench/sssm_slave_model.sv
// behavioural spi slave standing on the far side of the master
`timescale 1ns/10ps
module sssm_slave_model (
  input  wire logic       clk,
  input  wire logic       sck,
  input  wire logic       sdo,
  input  wire logic       clock_idle_polarity,
  input  wire logic       cke,
  input  wire logic       ld,
  input  wire logic [7:0] ld_val,
  output logic            sdi,
  output logic      [7:0] rx
);
  logic [7:0] sh_r;
  logic [4:0] cnt_r;
  logic       sck_r;
  logic       live_r;
  wire        seen = sck ^ sck_r;
  wire        lead = sck ^ clock_idle_polarity;
  // released line shows the inverse, so a stale bit never passes
  assign sdi = live_r ? sh_r[7] : ~sh_r[7];
  always_ff @(posedge clk)
  begin
    sck_r <= sck;
    if (ld)
    begin
      sh_r   <= ld_val;
      cnt_r  <= 5'h00;
      live_r <= 1'h1;
    end
    else if (seen)
    begin
      cnt_r <= cnt_r + 5'h01;
      if (cnt_r == 5'h0F)
        live_r <= 1'h0;
      if (lead == cke)
        rx <= {rx[6:0], sdo};
      else if (cke || cnt_r != 5'h00)
        sh_r <= {sh_r[6:0], 1'h0};
    end
  end
endmodule

// >>> testbench/sync_serial_spi_mode_tb.sv
// self-checking bench for the spi mode of the serial port
`timescale 1ns/10ps
`include "sssm_map.svh"
module sync_serial_spi_mode_tb;
  localparam logic [1:0] a_st = `SSSM_ADDR_STATUS;
  localparam logic [1:0] a_ct = `SSSM_ADDR_CONTROL;
  localparam logic [1:0] a_bu = `SSSM_ADDR_BUFFER;
  localparam logic [1:0] a_if = `SSSM_ADDR_INTFLAG;
  logic       clk, rst_n, clk_en, reg_wr, reg_rd, timer_tick, sck_in;
  logic       sdi_in, ss_n_in, sck_out, sck_oe, sdo_out, sdo_oe;
  logic       pins_owned, irq, m_sdi, ld, clock_idle_polarity, cke, slv;
  logic [1:0] reg_addr, tc;
  logic [7:0] reg_wdata, reg_rdata, ld_val, rx, rd_v, got;
  int         fails, num_checks, n;
  logic [3:0] t_mode [5] = '{`SSSM_MODE_DIV4, `SSSM_MODE_DIV16,
    `SSSM_MODE_DIV64, `SSSM_MODE_TMR, `SSSM_MODE_DIV8};
  int         t_h [5] = '{2, 8, 32, 3, 4};
  logic [7:0] t_d [5] = '{8'hA5, 8'h3C, 8'h81, 8'h5E, 8'h07};
  logic [4:0] t_ckp = 5'h0C;
  logic [4:0] t_cke = 5'h15;
  logic [4:0] t_smp = 5'h18;

  sssm_port i_sssm_port (
    .clk(clk), .rst_n(rst_n), .clk_en(clk_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .timer_tick(timer_tick), .sck_in(sck_in),
    .sck_out(sck_out), .sck_oe(sck_oe), .sdi_in(slv ? sdi_in : m_sdi),
    .sdo_out(sdo_out), .sdo_oe(sdo_oe), .ss_n_in(ss_n_in),
    .pins_owned(pins_owned), .port_interrupt_flag(irq)
  );
  sssm_slave_model i_sssm_slave_model (
    .clk(clk), .sck(sck_out), .sdo(sdo_out), .clock_idle_polarity(clock_idle_polarity), .cke(cke),
    .ld(ld), .ld_val(ld_val), .sdi(m_sdi), .rx(rx)
  );
  //////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'h0;
    forever #12.5 clk = ~clk;
  end
  // tick every third cycle, so timer mode has a known half-period
  always @(posedge clk)
  begin
    tc <= (tc == 2'h2) ? 2'h0 : tc + 2'h1;
    timer_tick <= (tc == 2'h2);
  end
  initial
  begin
    #1500000;
    fails++;
    wrap_up;
  end
  //////////////////////////////////////////////////////////////////////////
  task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge clk);
    reg_wr <= 1'h0;
  endtask
  task rd(input logic [1:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge clk);
    reg_rd <= 1'h0;
    #1 d = reg_rdata;
  endtask
  task ldm(input logic [7:0] v);
    @(posedge clk);
    ld <= 1'h1;
    ld_val <= v;
    @(posedge clk);
    ld <= 1'h0;
  endtask
  // polling costs two cycles a read; 400 covers the slowest divider
  task wait_bf;
    int k;
    k = 0;
    rd_v = 8'h00;
    while (rd_v[0] !== 1'h1 && k < 400)
    begin
      rd(a_st, rd_v);
      k++;
    end
    if (k == 400)
      fails++;
  endtask
  task half(output int h);
    logic s;
    int   k;
    s = sck_out;
    k = 0;
    while (sck_out === s && k < 200)
    begin
      @(posedge clk);
      #1 k++;
    end
    s = sck_out;
    h = 0;
    while (sck_out === s && h < 200)
    begin
      @(posedge clk);
      #1 h++;
    end
  endtask
  task sbits(input int nb, input logic [7:0] tx);
    for (int i = 7; i > 7 - nb; i--)
    begin
      sdi_in <= tx[i];
      repeat (2) @(posedge clk);
      sck_in <= 1'h1;
      repeat (2) @(posedge clk);
      got[i] = sdo_out;
      sck_in <= 1'h0;
      repeat (2) @(posedge clk);
    end
    sdi_in <= ~sdi_in;
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial
  begin
    {clk_en, reg_wr, reg_rd, sck_in, sdi_in, ss_n_in} = 6'h21;
    {ld, clock_idle_polarity, cke, slv} = 4'h0;
    {tc, reg_addr, reg_wdata, ld_val} = 20'h00000;
    {fails, num_checks} = 0;
    rst_n = 1'h0;
    repeat (10) @(posedge clk);
    rst_n <= 1'h1;
    #1 chk("pins", {2'h0, sck_out, sck_oe, sdo_out, sdo_oe, pins_owned, irq},
           8'h00);
    rd(a_st, rd_v);
    chk("status", rd_v, `SSSM_RESET_STATUS);
    rd(a_ct, rd_v);
    chk("control", rd_v, `SSSM_RESET_CONTROL);
    wr(a_st, 8'hFF);
    rd(a_st, rd_v);
    chk("status ro", rd_v, 8'hC0);
    @(posedge clk);
    clk_en <= 1'h0;
    wr(a_ct, 8'h20);
    clk_en <= 1'h1;
    rd(a_ct, rd_v);
    chk("frozen", rd_v, 8'h00);
    for (int i = 0; i < 5; i++)
    begin
      clock_idle_polarity = t_ckp[i];
      cke = t_cke[i];
      wr(a_st, {t_smp[i], t_cke[i], 6'h00});
      wr(a_ct, {3'h1, t_ckp[i], t_mode[i]});
      #1 chk("idle", {5'h00, pins_owned, sck_oe, sck_out},
             {6'h03, t_ckp[i]});
      ldm(~t_d[i]);
      wr(a_bu, t_d[i]);
      half(n);
      chk("half", 8'(n), 8'(t_h[i]));
      wait_bf;
      chk("irq", {7'h00, irq}, 8'h01);
      rd(a_if, rd_v);
      chk("intf", rd_v, 8'h01);
      rd(a_bu, rd_v);
      chk("rx", rd_v, ~t_d[i]);
      chk("tx", rx, t_d[i]);
      wr(a_if, 8'h00);
      #1 chk("irq clr", {7'h00, irq}, 8'h00);
      rd(a_st, rd_v);
      chk("bf", rd_v, {t_smp[i], t_cke[i], 6'h00});
    end
    clock_idle_polarity = 1'h0;
    cke = 1'h1;
    wr(a_st, 8'h40);
    wr(a_ct, 8'h20);
    ldm(8'hF0);
    wr(a_bu, 8'h11);
    wr(a_bu, 8'h22);
    wait_bf;
    chk("collide", rx, 8'h11);
    rd(a_ct, rd_v);
    chk("write_collision_flag", rd_v, 8'hA0);
    ldm(8'h0F);
    wr(a_bu, 8'h33);
    repeat (40) @(posedge clk);
    chk("tx2", rx, 8'h33);
    rd(a_ct, rd_v);
    chk("no ovf", rd_v, 8'hA0);
    wr(a_ct, 8'h20);
    rd(a_ct, rd_v);
    chk("write_collision_flag clr", rd_v, 8'h20);
    rd(a_bu, rd_v);
    wr(a_ct, 8'h26);
    wr(a_bu, 8'h77);
    repeat (80) @(posedge clk);
    chk("rsv", {6'h00, sck_oe, sdo_oe}, 8'h00);
    rd(a_st, rd_v);
    chk("rsv bf", rd_v, 8'h40);
    wr(a_ct, 8'h20);
    wr(a_bu, 8'h55);
    wr(a_ct, 8'h00);
    @(posedge clk);
    #1 chk("abort", {6'h00, sck_oe, sck_out}, 8'h00);
    repeat (40) @(posedge clk);
    rd(a_st, rd_v);
    chk("abort bf", rd_v, 8'h40);
    slv = 1'h1;
    ss_n_in <= 1'h0;
    wr(a_st, 8'h00);
    wr(a_ct, 8'h24);
    wr(a_bu, 8'h96);
    sbits(8, 8'hC3);
    chk("sdo", got, 8'h96);
    wait_bf;
    rd(a_bu, rd_v);
    chk("srx", rd_v, 8'hC3);
    sbits(8, 8'h3D);
    wait_bf;
    sbits(8, 8'h5A);
    repeat (4) @(posedge clk);
    rd(a_ct, rd_v);
    chk("ovf", rd_v, 8'h64);
    rd(a_bu, rd_v);
    chk("kept", rd_v, 8'h3D);
    wr(a_ct, 8'h24);
    sbits(3, 8'hFF);
    ss_n_in <= 1'h1;
    repeat (3) @(posedge clk);
    #1 chk("float", {7'h00, sdo_oe}, 8'h00);
    @(posedge clk);
    ss_n_in <= 1'h0;
    sbits(8, 8'h81);
    wait_bf;
    rd(a_bu, rd_v);
    chk("restart", rd_v, 8'h81);
    wr(a_ct, 8'h25);
    ss_n_in <= 1'h1;
    wr(a_bu, 8'hE1);
    sbits(8, 8'h6B);
    chk("free pins", {6'h00, sck_oe, sdo_oe}, 8'h01);
    chk("free sdo", got, 8'hE1);
    wait_bf;
    rd(a_bu, rd_v);
    chk("free", rd_v, 8'h6B);
    wr(a_ct, 8'h04);
    #1 chk("owned", {7'h00, pins_owned}, 8'h00);
    wrap_up;
  end
endmodule
